/* File: rtl/sbp_regs.svh */
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH

// ********************************************************************
// Register byte offsets on the AXI4-Lite bus.
// ********************************************************************
`define SBP_OFF_D_DATA 8'h00
`define SBP_OFF_D_LATCH 8'h04
`define SBP_OFF_D_DIR 8'h08
`define SBP_OFF_E_PINS 8'h0C
`define SBP_OFF_E_LATCH 8'h10
`define SBP_OFF_E_DIR 8'h14
`define SBP_OFF_SLEW 8'h18
`define SBP_OFF_FLAG 8'h1C
`define SBP_OFF_IRQ_EN 8'h20
`define SBP_OFF_IRQ_PRIO 8'h24
`define SBP_OFF_ANA_SEL 8'h28
`define SBP_OFF_PWM_CFG 8'h2C

// ********************************************************************
// Field positions.
// ********************************************************************
`define SBP_BIT_IN_FULL 7
`define SBP_BIT_OUT_FULL 6
`define SBP_BIT_IN_OVF 5
`define SBP_BIT_MODE 4
`define SBP_BIT_IRQ 7
`define SBP_BIT_ANS_E 5

// ********************************************************************
// Reset values and bus answers.
// ********************************************************************
`define SBP_RST_D_DIR 8'hFF
`define SBP_RST_E_DIR 3'h7
`define SBP_RST_ANA_SEL 8'hFF
`define SBP_RST_SLEW 5'h1F
`define SBP_RST_STROBES 3'h7
`define SBP_RESP_OKAY 2'h0
`define SBP_RESP_SLVERR 2'h2

`endif

/* File: rtl/sbp_pkg.sv */
package sbp_pkg;
	`include "sbp_regs.svh"

	// Handshake state of the external byte port.
	typedef enum logic [1:0] {SBP_IDLE = 2'b00, SBP_WRITE = 2'b01, SBP_READ = 2'b10} sbp_xfer_t;
	// Output configuration of the capture/compare/PWM unit.
	typedef enum logic [1:0] {SBP_PWM_SINGLE = 2'b00, SBP_PWM_DUAL = 2'b01,
		SBP_PWM_QUAD_FWD = 2'b10, SBP_PWM_QUAD_REV = 2'b11} sbp_pwm_out_t;
	// Register selector produced by the address decoder.
	typedef enum logic [3:0] {SBP_R_D_DATA = 4'h0, SBP_R_D_LATCH = 4'h1, SBP_R_D_DIR = 4'h2,
		SBP_R_E_PINS = 4'h3, SBP_R_E_LATCH = 4'h4, SBP_R_E_DIR = 4'h5, SBP_R_SLEW = 4'h6,
		SBP_R_FLAG = 4'h7, SBP_R_IRQ_EN = 4'h8, SBP_R_IRQ_PRIO = 4'h9, SBP_R_ANA_SEL = 4'hA,
		SBP_R_PWM_CFG = 4'hB, SBP_R_NONE = 4'hF} sbp_reg_t;

	typedef struct packed {
		logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic bready; logic arvalid; logic [7:0] araddr; logic rready;
	} sbp_axi_req_t;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} sbp_axi_rsp_t;
	typedef struct packed {
		logic [7:0] d; logic [2:0] e;
	} sbp_pins_in_t;
	typedef struct packed {
		logic [7:0] d; logic [7:0] d_oe; logic [2:0] e; logic [2:0] e_oe; logic [4:0] slew;
	} sbp_pins_out_t;

	// State of the port block apart from the input FIFO.
	typedef struct packed {
		logic [2:0] sync1; logic [2:0] sync2; sbp_xfer_t xfer; logic [7:0] cap;
		logic [7:0] d_lat; logic [7:0] d_dir; logic [2:0] late; logic [2:0] tris_e;
		logic mode; logic output_buffer_full; logic input_overflow; logic irq; logic irq_en; logic irq_prio;
		logic [4:0] slew; logic [7:0] ana_sel; sbp_pwm_out_t pwm;
		logic aw_got; logic [7:0] aw_addr; logic w_got; logic [7:0] wdata; logic wstrb0;
		logic bvalid; logic [1:0] bresp; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
	} sbp_state_t;

	// Maps a byte address onto a register; anything else is unmapped.
	function automatic sbp_reg_t sbp_decode(input logic [7:0] addr);
		case (addr)
			`SBP_OFF_D_DATA: sbp_decode = SBP_R_D_DATA;
			`SBP_OFF_D_LATCH: sbp_decode = SBP_R_D_LATCH;
			`SBP_OFF_D_DIR: sbp_decode = SBP_R_D_DIR;
			`SBP_OFF_E_PINS: sbp_decode = SBP_R_E_PINS;
			`SBP_OFF_E_LATCH: sbp_decode = SBP_R_E_LATCH;
			`SBP_OFF_E_DIR: sbp_decode = SBP_R_E_DIR;
			`SBP_OFF_SLEW: sbp_decode = SBP_R_SLEW;
			`SBP_OFF_FLAG: sbp_decode = SBP_R_FLAG;
			`SBP_OFF_IRQ_EN: sbp_decode = SBP_R_IRQ_EN;
			`SBP_OFF_IRQ_PRIO: sbp_decode = SBP_R_IRQ_PRIO;
			`SBP_OFF_ANA_SEL: sbp_decode = SBP_R_ANA_SEL;
			`SBP_OFF_PWM_CFG: sbp_decode = SBP_R_PWM_CFG;
			default: sbp_decode = SBP_R_NONE;
		endcase
	endfunction : sbp_decode
endpackage : sbp_pkg

/* File: rtl/sbp_top.sv */
`timescale 1ns/1ps

// ********************************************************************
// Byte FIFO between the external write strobe and software.
// ********************************************************************
module sbp_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock, reset and freeze.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Filling side.
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	// Draining side.
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(D);

	// All FIFO state in one word: storage, pointers and fill level.
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sbp_fifo_st_t;

	sbp_fifo_st_t st_ff; // Registered state.
	sbp_fifo_st_t nxt_st; // Next state.
	logic push; // Word accepted this cycle.
	logic pop; // Word drained this cycle.

	// Full and empty come straight from the fill level, so they never lie.
	assign o_in_ready = (st_ff.cnt != (AW+1)'(D));
	assign o_out_valid = (st_ff.cnt != '0);
	assign o_out_data = st_ff.mem[st_ff.rp];
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;

	// Pointer and level update; the pointers wrap because the depth is a power of two.
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp] = i_in_data;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage is not cleared at reset; only the pointers and the fill level are reset.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_ff.wp <= '0;
			st_ff.rp <= '0;
			st_ff.cnt <= '0;
		end else if (i_clk_en) begin
			st_ff <= nxt_st;
		end
	end
endmodule : sbp_fifo

// How it works
// R1: Direction register bit 4 enables slave mode.
// R2: Slave mode blocked by dual/quad PWM output.
// R3: External master reads/writes port D latch bytewise.
// R4: Pins E0 read, E1 write, E2 select.
// R5: Software sets E directions, clears analog selects.
// R6: Write spans select and write both low.
// R7: Write end sets flag and input full.
// R8: Read start drives latch, clears output full.
// R9: Software port write sets output full.
// R10: Write during read: drive now, output full stays.
// R11: Read end releases pins, sets flag.
// R12: Software waits for flag, then polls.
// R13: Analog select masks digital input to zero.
// R14: Software read clears input full; overflow flag.
// R15: Strobes synchronised before edge detection.
module sbp_top
	import sbp_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// AXI4-Lite register slave.
	input wire sbp_axi_req_t i_axi_req,
	output sbp_axi_rsp_t o_axi_rsp,
	// Port D and port E pins.
	input wire sbp_pins_in_t i_pins,
	output sbp_pins_out_t o_pins
);
	// ********************************************************************
	// Declarations.
	// ********************************************************************
	sbp_state_t st_ff; // Registered state of the block apart from the input FIFO.
	sbp_state_t nxt_st; // Next state.
	logic [2:0] e_in; // Port E digital inputs after analog masking.
	logic en_slave; // Slave mode really active.
	logic wr_go; // Select and write strobe both seen low.
	logic rd_go; // Select and read strobe both seen low.
	logic aw_hs; // Write address taken.
	logic w_hs; // Write data taken.
	logic ar_hs; // Read address taken.
	logic sw_wr; // Buffered register write fires.
	logic lat_wr; // Software writes the port D latch.
	sbp_reg_t wr_reg; // Register selected by the held write address.
	sbp_reg_t rd_reg; // Register selected by the read address.
	logic [7:0] rd_val; // Read data before it is registered.
	logic read_start; // Read transfer begins this cycle.
	logic write_end; // Write transfer ends this cycle.
	logic read_end; // Read transfer ends this cycle.
	logic fifo_in_ready; // Input FIFO can take a byte.
	logic fifo_valid; // Input FIFO holds a byte.
	logic [7:0] fifo_data; // Oldest received byte.
	logic fifo_pop; // Software read takes the oldest byte.

	// ********************************************************************
	// Pin decode.
	// ********************************************************************

	// A pin with its analog select set reads as zero, so leaving those bits set
	// turns every strobe into a permanent low.
	assign e_in = i_pins.e & ~st_ff.ana_sel[`SBP_BIT_ANS_E +: 3]; // R13 R5
	// Mode bit only counts while the PWM unit drives a single output.
	assign en_slave = st_ff.mode & (st_ff.pwm == SBP_PWM_SINGLE); // R1 R2
	// Bit 0 is read, bit 1 write, bit 2 select, all active low.
	assign wr_go = en_slave & ~st_ff.sync2[2] & ~st_ff.sync2[1]; // R4 R6
	assign rd_go = en_slave & ~st_ff.sync2[2] & ~st_ff.sync2[0]; // R4

	// ********************************************************************
	// Bus decode.
	// ********************************************************************
	assign wr_reg = sbp_decode(st_ff.aw_addr);
	assign rd_reg = sbp_decode(i_axi_req.araddr);
	assign aw_hs = i_axi_req.awvalid & o_axi_rsp.awready;
	assign w_hs = i_axi_req.wvalid & o_axi_rsp.wready;
	assign ar_hs = i_axi_req.arvalid & o_axi_rsp.arready;
	assign sw_wr = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
	assign lat_wr = sw_wr & st_ff.wstrb0 & ((wr_reg == SBP_R_D_DATA) | (wr_reg == SBP_R_D_LATCH));
	// A software read of the data register drains one received byte.
	assign fifo_pop = ar_hs & (rd_reg == SBP_R_D_DATA) & fifo_valid; // R14

	// Ready outputs are gated by the clock enable so no beat is lost while frozen.
	assign o_axi_rsp.awready = i_clk_en & ~st_ff.aw_got & ~st_ff.bvalid;
	assign o_axi_rsp.wready = i_clk_en & ~st_ff.w_got & ~st_ff.bvalid;
	assign o_axi_rsp.arready = i_clk_en & ~st_ff.rvalid;
	assign o_axi_rsp.bvalid = st_ff.bvalid;
	assign o_axi_rsp.bresp = st_ff.bresp;
	assign o_axi_rsp.rvalid = st_ff.rvalid;
	assign o_axi_rsp.rdata = {24'h00_0000, st_ff.rdata};
	assign o_axi_rsp.rresp = st_ff.rresp;

	// ********************************************************************
	// Pin drive.
	// ********************************************************************

	// The latch always sits on the pins, so a write during a read shows at once.
	assign o_pins.d = st_ff.d_lat; // R3 R10
	// In slave mode port D drives only inside a read transfer.
	assign o_pins.d_oe = en_slave ? {8{st_ff.xfer == SBP_READ}} : ~st_ff.d_dir; // R8 R11
	assign o_pins.e = st_ff.late;
	assign o_pins.e_oe = en_slave ? 3'h0 : ~st_ff.tris_e;
	assign o_pins.slew = st_ff.slew;

	// Received bytes queue here; a full queue is what raises overflow.
	sbp_fifo #(
		.W(8),
		.D(16)
	) u_in_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_in_valid(write_end),
		.i_in_data(st_ff.cap),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// ********************************************************************
	// Read multiplexer.
	// ********************************************************************

	// Status bits input full and output full are read only.
	always_comb begin
		case (rd_reg)
			SBP_R_D_DATA: rd_val = fifo_valid ? fifo_data : i_pins.d;
			SBP_R_D_LATCH: rd_val = st_ff.d_lat;
			SBP_R_D_DIR: rd_val = st_ff.d_dir;
			SBP_R_E_PINS: rd_val = {5'h00, e_in}; // R13
			SBP_R_E_LATCH: rd_val = {5'h00, st_ff.late};
			SBP_R_E_DIR: rd_val = {fifo_valid, st_ff.output_buffer_full, st_ff.input_overflow, st_ff.mode, 1'b0, st_ff.tris_e};
			SBP_R_SLEW: rd_val = {3'h0, st_ff.slew};
			SBP_R_FLAG: rd_val = {st_ff.irq, 7'h00};
			SBP_R_IRQ_EN: rd_val = {st_ff.irq_en, 7'h00};
			SBP_R_IRQ_PRIO: rd_val = {st_ff.irq_prio, 7'h00};
			SBP_R_ANA_SEL: rd_val = st_ff.ana_sel;
			SBP_R_PWM_CFG: rd_val = {6'h00, st_ff.pwm};
			default: rd_val = 8'h00;
		endcase
	end

	// ********************************************************************
	// Next state.
	// ********************************************************************

	// Software effects are applied first and hardware events last, so an event
	// landing in the cycle of a clear always wins.
	always_comb begin
		nxt_st = st_ff;
		read_start = 1'b0;
		write_end = 1'b0;
		read_end = 1'b0;
		// Two flops per strobe; nothing but the second flop looks at the first.
		nxt_st.sync1 = e_in; // R15
		nxt_st.sync2 = st_ff.sync1; // R15
		// Transfer tracking; a write wins if both strobes fall together.
		case (st_ff.xfer)
			SBP_IDLE: begin
				if (wr_go) begin
					nxt_st.xfer = SBP_WRITE; // R6
					nxt_st.cap = i_pins.d;
				end else if (rd_go) begin
					nxt_st.xfer = SBP_READ; // R8
					read_start = 1'b1;
				end
			end
			SBP_WRITE: begin
				// The byte kept is the last one seen while the strobes were low.
				if (wr_go) begin
					nxt_st.cap = i_pins.d; // R3
				end else begin
					nxt_st.xfer = SBP_IDLE; // R6
					write_end = 1'b1;
				end
			end
			SBP_READ: begin
				if (!rd_go) begin
					nxt_st.xfer = SBP_IDLE; // R11
					read_end = 1'b1;
				end
			end
			default: begin
				nxt_st.xfer = SBP_IDLE;
			end
		endcase
		// Write address and data may arrive in either order.
		if (aw_hs) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = i_axi_req.awaddr;
		end
		if (w_hs) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = i_axi_req.wdata[7:0];
			nxt_st.wstrb0 = i_axi_req.wstrb[0];
		end
		if (st_ff.bvalid && i_axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Register write once both halves are held; lane 0 carries all data.
		if (sw_wr) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (wr_reg == SBP_R_NONE) ? `SBP_RESP_SLVERR : `SBP_RESP_OKAY;
			if (st_ff.wstrb0) begin
				case (wr_reg)
					SBP_R_D_DATA, SBP_R_D_LATCH: nxt_st.d_lat = st_ff.wdata;
					SBP_R_D_DIR: nxt_st.d_dir = st_ff.wdata;
					SBP_R_E_PINS, SBP_R_E_LATCH: nxt_st.late = st_ff.wdata[2:0];
					SBP_R_E_DIR: begin
						nxt_st.mode = st_ff.wdata[`SBP_BIT_MODE]; // R1
						nxt_st.tris_e = st_ff.wdata[2:0];
						if (!st_ff.wdata[`SBP_BIT_IN_OVF]) begin
							nxt_st.input_overflow = 1'b0;
						end
					end
					SBP_R_SLEW: nxt_st.slew = st_ff.wdata[4:0];
					SBP_R_FLAG: begin
						if (!st_ff.wdata[`SBP_BIT_IRQ]) begin
							nxt_st.irq = 1'b0;
						end
					end
					SBP_R_IRQ_EN: nxt_st.irq_en = st_ff.wdata[`SBP_BIT_IRQ];
					SBP_R_IRQ_PRIO: nxt_st.irq_prio = st_ff.wdata[`SBP_BIT_IRQ];
					SBP_R_ANA_SEL: nxt_st.ana_sel = st_ff.wdata;
					SBP_R_PWM_CFG: nxt_st.pwm = sbp_pwm_out_t'(st_ff.wdata[1:0]); // R2
					default: begin
					end
				endcase
			end
		end
		// Output full marks a byte waiting, but never inside a read.
		if (lat_wr && (st_ff.xfer != SBP_READ) && !read_start) begin
			nxt_st.output_buffer_full = 1'b1; // R9 R10
		end
		if (read_start) begin
			nxt_st.output_buffer_full = 1'b0; // R8
		end
		// Either transfer ending raises the port flag.
		if (write_end || read_end) begin
			nxt_st.irq = 1'b1; // R7 R11
		end
		// A byte with nowhere to go is dropped and flagged.
		if (write_end && !fifo_in_ready) begin
			nxt_st.input_overflow = 1'b1; // R14
		end
		// Register read answer.
		if (st_ff.rvalid && i_axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (ar_hs) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_val;
			nxt_st.rresp = (rd_reg == SBP_R_NONE) ? `SBP_RESP_SLVERR : `SBP_RESP_OKAY;
		end
	end

	// ********************************************************************
	// State register.
	// ********************************************************************

	// Synchronous reset to constants; the clock enable freezes everything else.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.sync1 <= `SBP_RST_STROBES;
			st_ff.sync2 <= `SBP_RST_STROBES;
			st_ff.d_dir <= `SBP_RST_D_DIR;
			st_ff.tris_e <= `SBP_RST_E_DIR;
			st_ff.ana_sel <= `SBP_RST_ANA_SEL;
			st_ff.slew <= `SBP_RST_SLEW;
		end else if (i_clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// ********************************************************************
	// Assertions.
	// ********************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_write_ends;
		i_clk_en && (st_ff.xfer == SBP_WRITE) && !wr_go;
	endsequence
	sequence s_read_starts;
		i_clk_en && (st_ff.xfer == SBP_IDLE) && !wr_go && rd_go;
	endsequence
	sequence s_two_enabled;
		i_clk_en ##1 i_clk_en;
	endsequence

	property p_write_start;
		i_clk_en && (st_ff.xfer == SBP_IDLE) && wr_go |=> (st_ff.xfer == SBP_WRITE);
	endproperty
	a_write_start: assert property (p_write_start) else $error("write transfer did not start"); // R6

	property p_write_end_flags;
		s_write_ends and fifo_in_ready |=> st_ff.irq && fifo_valid && (st_ff.xfer == SBP_IDLE);
	endproperty
	a_write_end_flags: assert property (p_write_end_flags) else $error("write end left flags clear"); // R7

	property p_overflow;
		s_write_ends and !fifo_in_ready |=> st_ff.input_overflow;
	endproperty
	a_overflow: assert property (p_overflow) else $error("lost byte did not set overflow"); // R14

	property p_read_start;
		s_read_starts |=> !st_ff.output_buffer_full && (o_pins.d_oe == 8'hFF) ##1 (st_ff.xfer != SBP_IDLE) || !rd_go;
	endproperty
	a_read_start: assert property (p_read_start) else $error("read start did not drive port"); // R8

	property p_read_end;
		i_clk_en && (st_ff.xfer == SBP_READ) && !rd_go |=> st_ff.irq && (st_ff.xfer == SBP_IDLE);
	endproperty
	a_read_end: assert property (p_read_end) else $error("read end did not release port"); // R11

	property p_obf_set;
		i_clk_en && lat_wr && (st_ff.xfer != SBP_READ) && !read_start |=> st_ff.output_buffer_full;
	endproperty
	a_obf_set: assert property (p_obf_set) else $error("port write did not set output full"); // R9

	property p_obf_kept;
		i_clk_en && lat_wr && (st_ff.xfer == SBP_READ) |=> !st_ff.output_buffer_full && (o_pins.d == $past(st_ff.wdata));
	endproperty
	a_obf_kept: assert property (p_obf_kept) else $error("write during read mishandled"); // R10

	property p_gate;
		i_clk_en && !en_slave && (st_ff.xfer == SBP_IDLE) |=> (st_ff.xfer == SBP_IDLE);
	endproperty
	a_gate: assert property (p_gate) else $error("transfer started while slave mode off"); // R2

	property p_sync;
		s_two_enabled |=> (st_ff.sync2 == $past(e_in, 2));
	endproperty
	a_sync: assert property (p_sync) else $error("strobe synchroniser delay wrong"); // R15

	property p_analog_mask;
		(st_ff.ana_sel[7:5] == 3'h7) |-> (e_in == 3'h0);
	endproperty
	a_analog_mask: assert property (p_analog_mask) else $error("masked pin read non-zero"); // R13
endmodule : sbp_top

/* File: dv/sbp_host_model.sv */
`timescale 1ns/1ps

// ****
// External byte-bus master driving select, strobes and port D.
// ****
module sbp_host_model
	import sbp_pkg::*;
(
	// Clock.
	input wire logic i_sys_clk,
	// Device pins.
	input wire sbp_pins_out_t i_dev,
	output sbp_pins_in_t o_pins
);
	logic [2:0] strb_n = 3'h7; // Select, write, read; all idle high.
	logic [7:0] drv = 8'h00; // Byte this master puts on port D.
	logic drv_en = 1'h0; // High while this master drives port D.
	logic [7:0] last_d = 8'h00; // Last bus level seen.

	// Each D line follows its driver; a released line shows the inverse, since it has no pull.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			o_pins.d[i] = i_dev.d_oe[i] ? i_dev.d[i] : (drv_en ? drv[i] : ~last_d[i]);
		end
		o_pins.e = strb_n;
	end

	// Remember the bus so a floating line keeps changing.
	always_ff @(posedge i_sys_clk) begin
		last_d <= o_pins.d;
	end

	// One write: data stays 4 clocks past the strobe rise, beyond the 2 the sampler needs.
	task automatic ext_write(input logic [7:0] b);
		@(posedge i_sys_clk);
		strb_n <= 3'h1;
		drv <= b;
		drv_en <= 1'h1;
		repeat (4) @(posedge i_sys_clk);
		strb_n <= 3'h7;
		repeat (4) @(posedge i_sys_clk);
		drv_en <= 1'h0;
		repeat (2) @(posedge i_sys_clk);
	endtask : ext_write

	// Opens a read and waits until the device must be driving.
	task automatic read_open();
		@(posedge i_sys_clk);
		strb_n <= 3'h2;
		repeat (5) @(posedge i_sys_clk);
	endtask : read_open

	// Takes the byte at this edge, then ends the read.
	task automatic read_close(output logic [7:0] b);
		b = o_pins.d;
		strb_n <= 3'h7;
		repeat (5) @(posedge i_sys_clk);
	endtask : read_close
endmodule : sbp_host_model

/* File: dv/sbp_top_bench.sv */
`timescale 1ns/1ps

// ****
// Self-checking bench for the byte port.
// ****
module sbp_top_bench;
	import sbp_pkg::*;
	logic i_sys_clk = 1'h0; // 20 MHz clock.
	logic i_rst = 1'h1; // Held for 8 cycles.
	logic i_clk_en = 1'h1; // Freeze control.
	sbp_axi_req_t req = '0; // Bus master outputs.
	sbp_axi_rsp_t rsp; // Bus slave answers.
	sbp_pins_in_t pins; // Resolved pin levels.
	sbp_pins_out_t pout; // Device pin drive.
	int error_cnt = 0; // Mismatches.
	int compares = 0; // Comparisons made.
	logic [7:0] b, b0, r8; // Bytes in flight.
	logic [7:0] q[$]; // Bytes expected from the FIFO.

	sbp_top u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
		.i_axi_req(req), .o_axi_rsp(rsp), .i_pins(pins), .o_pins(pout));
	sbp_host_model u_host (.i_sys_clk(i_sys_clk), .i_dev(pout), .o_pins(pins));

	// Clock generator.
	initial begin
		forever #25 i_sys_clk = ~i_sys_clk;
	end

	// Prints the counts and the verdict.
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Value compare.
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk_val

	// Bus response compare.
	task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk_resp

	// A wait that runs out ends the run.
	task automatic hang(input int n);
		if (n >= 100) begin
			error_cnt++;
			$display("CHECK FAILED bus wait exp answer got none");
			tally_and_finish();
		end
	endtask : hang

	// Write: both halves offered together, each dropped when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic aw;
		logic w;
		logic ta;
		logic tw;
		logic bv;
		logic [1:0] br;
		aw = 1'h1;
		w = 1'h1;
		br = 2'h0;
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= {24'h00_0000, d};
		req.wstrb <= 4'h1;
		req.bready <= 1'h1;
		for (n = 0; n < 100; n++) begin
			// Answers are settled mid-cycle and stand until the next rising edge.
			@(negedge i_sys_clk);
			ta = aw && (rsp.awready === 1'h1);
			tw = w && (rsp.wready === 1'h1);
			bv = (rsp.bvalid === 1'h1);
			br = rsp.bresp;
			@(posedge i_sys_clk);
			if (ta) begin
				aw = 1'h0;
				req.awvalid <= 1'h0;
			end
			if (tw) begin
				w = 1'h0;
				req.wvalid <= 1'h0;
			end
			if (bv) break;
		end
		hang(n);
		chk_resp("bresp", er, br);
		req.bready <= 1'h0;
		@(posedge i_sys_clk);
	endtask : axi_wr

	// Read: rready held until rvalid is seen.
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta;
		logic rv;
		d = 32'h0000_0000;
		r = 2'h0;
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		for (n = 0; n < 100; n++) begin
			@(negedge i_sys_clk);
			ta = (rsp.arready === 1'h1);
			rv = (rsp.rvalid === 1'h1);
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge i_sys_clk);
			if (ta) req.arvalid <= 1'h0;
			if (rv) break;
		end
		hang(n);
		req.rready <= 1'h0;
		@(posedge i_sys_clk);
	endtask : axi_rd

	// Reads a register and compares the masked byte.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_resp("rresp", 2'h0, r);
		chk_val($sformatf("reg %h", a), {24'h00_0000, e}, d & {24'h00_0000, m});
	endtask : rd_chk

	// ****
	// Main sequence.
	// ****
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(15));
		repeat (8) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		// Reset values and an unmapped place.
		rd_chk(8'h08, 8'hFF, 8'hFF);
		rd_chk(8'h14, 8'hFF, 8'h07);
		rd_chk(8'h28, 8'hFF, 8'hFF);
		rd_chk(8'h18, 8'hFF, 8'h1F);
		chk_val("slew pins", 32'h0000_001F, {27'h000_0000, pout.slew});
		chk_val("e_oe", 32'h0000_0000, {29'h0000_0000, pout.e_oe});
		axi_rd(8'h30, d, r);
		chk_resp("unmapped", 2'h2, r);
		chk_val("unmapped data", 32'h0000_0000, d);
		axi_wr(8'h30, 8'h11, 2'h2);
		// A frozen clock enable refuses the bus.
		i_clk_en <= 1'h0;
		@(negedge i_sys_clk);
		chk_val("awready", 32'h0000_0000, {31'h0000_0000, rsp.awready});
		@(posedge i_sys_clk);
		i_clk_en <= 1'h1;
		// Strobes made digital; with the mode bit off a write is ignored.
		axi_wr(8'h28, 8'h00, 2'h0);
		u_host.ext_write(8'h5A);
		rd_chk(8'h1C, 8'h80, 8'h00);
		// Dual PWM output keeps the port off.
		axi_wr(8'h2C, 8'h01, 2'h0);
		axi_wr(8'h14, 8'h17, 2'h0);
		u_host.ext_write(8'hA5);
		rd_chk(8'h1C, 8'h80, 8'h00);
		axi_wr(8'h2C, 8'h00, 2'h0);
		// Write path: flag, then poll full, then pop.
		b = 8'($urandom);
		u_host.ext_write(b);
		rd_chk(8'h1C, 8'h80, 8'h80);
		rd_chk(8'h14, 8'h80, 8'h80);
		rd_chk(8'h00, 8'hFF, b);
		rd_chk(8'h14, 8'h80, 8'h00);
		// Read path with a software write in mid-read.
		axi_wr(8'h1C, 8'h00, 2'h0);
		b0 = 8'($urandom);
		axi_wr(8'h00, b0, 2'h0);
		rd_chk(8'h14, 8'h40, 8'h40);
		u_host.read_open();
		chk_val("d_oe", 32'h0000_00FF, {24'h00_0000, pout.d_oe});
		chk_val("d pins", {24'h00_0000, b0}, {24'h00_0000, pins.d});
		rd_chk(8'h14, 8'h40, 8'h00);
		b = 8'($urandom);
		axi_wr(8'h00, b, 2'h0);
		chk_val("d pins", {24'h00_0000, b}, {24'h00_0000, pins.d});
		rd_chk(8'h14, 8'h40, 8'h00);
		u_host.read_close(r8);
		chk_val("read byte", {24'h00_0000, b}, {24'h00_0000, r8});
		chk_val("d_oe", 32'h0000_0000, {24'h00_0000, pout.d_oe});
		rd_chk(8'h1C, 8'h80, 8'h80);
		rd_chk(8'h14, 8'h80, 8'h00);
		// Fill past 16 bytes, then drain in order.
		for (int i = 0; i < 17; i++) begin
			b = 8'($urandom);
			q.push_back(b);
			u_host.ext_write(b);
		end
		rd_chk(8'h14, 8'hA0, 8'hA0);
		for (int i = 0; i < 16; i++) begin
			rd_chk(8'h00, 8'hFF, q[i]);
		end
		rd_chk(8'h14, 8'h80, 8'h00);
		// Analog select masks a pin read to 0.
		axi_wr(8'h14, 8'h07, 2'h0);
		rd_chk(8'h0C, 8'h07, 8'h07);
		axi_wr(8'h28, 8'h20, 2'h0);
		rd_chk(8'h0C, 8'h07, 8'h06);
		tally_and_finish();
	end
endmodule : sbp_top_bench
